// ---- dac_latch_params.svh ----
// Purpose: Constants for the serial converter input latch
// Assumes: 100 MHz system clock
// Notes: Functional notes below
//
// Functional notes
// - Word is 12-bit straight binary, shifted in MSB first.
// - Output code maps linearly, 1 mV per step; FFF full, 800 mid.
// - Shifting leaves the held output unchanged while load strobe is high.
// - Falling load strobe copies the whole shift register to the output.
// - While load strobe is low, output register follows the shift register.
// - Clear low forces output register to zero at any time.
// - After clear, output stays zero until clear high and load taken low.
// - Load low at clear release sets output to shift register at once.
// - Shifting accepted only while chip select is low or as it rises.
// - Shift on rising clock with select low, or rising select, clock low.
`ifndef DAC_LATCH_PARAMS_SVH
`define DAC_LATCH_PARAMS_SVH
`define WORD_BITS 12
`define CODE_ZERO 12'h000
`define CODE_MID 12'h800
`define CODE_FULL 12'hfff
`define STEP_UV 1000
`define FIFO_DEPTH 16
// Pin idle levels {clear, load, select, data, clock}, {select, clock}
`define PIN_IDLE 5'h1c
`define EDGE_IDLE 2'h2
`endif

// ---- dac_latch_pkg.sv ----
// Purpose: Types for the serial converter input latch
// Assumes: Nothing
// Notes: Word carrier for the output path
package dac_latch_pkg;
    typedef logic [11:0] code_t;
    typedef struct packed {
        code_t code;
    } word_s;
endpackage : dac_latch_pkg

// ---- host_model.sv ----
// Purpose: Host model driving the converter serial pins
// Assumes: Link clock of 125 ns period, standing low between bits
// Notes: Data line shows the inverse bit once released
`timescale 1ns/1ps
module host_model (
    // Serial pins
    output logic sclk_out,
    output logic sdata_out,
    output logic cs_n_out,
    output logic ld_n_out,
    output logic clr_n_out
);
    localparam real HALF = 62.5;
    initial begin
        {sclk_out, sdata_out, cs_n_out, ld_n_out, clr_n_out} = 5'h07;
    end
    // One bit; clock mode deselects with clock high so no extra shift, select mode shifts on deselect with clock low
    task automatic bit_out(input logic b, input logic via_cs,
                           input logic sel);
        sdata_out = b;
        cs_n_out = ~(via_cs | sel);
        #HALF;
        sclk_out = ~via_cs;
        cs_n_out = cs_n_out | via_cs;
        #(HALF / 2);
        cs_n_out = 1'b1;
        #(HALF / 2);
        sclk_out = 1'b0;
        sdata_out = ~b;
    endtask : bit_out
    task automatic pins(input logic ld, input logic clr);
        ld_n_out = ld;
        clr_n_out = clr;
        #(4 * HALF);
    endtask : pins
endmodule : host_model

// ---- serial_dac_input_latch.sv ----
// Purpose: Serial input, double buffer and clear for a 12-bit converter
// Assumes: Pins are asynchronous to mclk_in and slow against it
// Notes: Output register words pass a FIFO to the analog code port
`timescale 1ns/1ps
`include "dac_latch_params.svh"

module code_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;
    assign in_ready_out = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid_out = wr_q != rd_q;
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem_q[rd_q[AW-1:0]];
    always_ff @(posedge mclk_in) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data_in;
        end
    end
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule : code_fifo

module serial_dac_input_latch
    import dac_latch_pkg::*;
#(
    parameter int WORD_BITS = `WORD_BITS,
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // Serial pins
    input wire logic serial_clk_in,
    input wire logic serial_data_in,
    input wire logic chip_select_n_in,
    input wire logic load_strobe_n_in,
    input wire logic async_clear_n_in,
    // Held code and analog code stream
    output logic [11:0] held_code_out,
    output logic analog_output_valid_out,
    input wire logic analog_output_ready_in,
    output logic [11:0] analog_output_out,
    output logic [31:0] analog_output_uv_out
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] meta_q;
    logic [4:0] sync_q;
    logic [1:0] prev_q;
    logic ld_prev_q;
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            // Idle levels, so no false edge follows reset
            meta_q <= `PIN_IDLE;
            sync_q <= `PIN_IDLE;
        end else begin
            meta_q <= {async_clear_n_in, load_strobe_n_in,
                       chip_select_n_in, serial_data_in, serial_clk_in};
            sync_q <= meta_q;
        end
    end
    logic s_clk;
    logic s_dat;
    logic s_cs_n;
    logic s_ld_n;
    logic s_clr_n;
    assign {s_clr_n, s_ld_n, s_cs_n, s_dat, s_clk} = sync_q;

    // ------------------------------------------------------------
    // Shift register
    // ------------------------------------------------------------
    logic [11:0] shift_q;
    logic shift_ev;
    logic gate_now;
    logic gate_prev;
    // Gated clock is clock or select: each of them rises the gate only while the other is low
    assign gate_now = s_clk || s_cs_n;
    assign gate_prev = prev_q[0] || prev_q[1];
    // Select held high keeps the gate high, so nothing shifts
    assign shift_ev = gate_now && !gate_prev;
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prev_q <= `EDGE_IDLE;
            ld_prev_q <= 1'b1;
        end else begin
            prev_q <= {s_cs_n, s_clk};
            ld_prev_q <= s_ld_n;
        end
    end
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            shift_q <= `CODE_ZERO;
        end else if (shift_ev) begin
            shift_q <= {shift_q[10:0], s_dat};
        end
    end

    // ------------------------------------------------------------
    // Output register
    // ------------------------------------------------------------
    logic [11:0] dac_q;
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dac_q <= `CODE_ZERO;
        end else if (!s_clr_n) begin
            dac_q <= `CODE_ZERO;
        end else if (!s_ld_n) begin
            // Edge, transparency, and clear release with load low
            dac_q <= shift_q;
        end
        // Load high: hold while shifting
    end
    assign held_code_out = dac_q;

    // ------------------------------------------------------------
    // Code stream to converter
    // ------------------------------------------------------------
    word_s last_q;
    logic fifo_ready;
    logic push;
    logic [11:0] fifo_data;
    // One push per change of held code; a full FIFO delays it
    assign push = (dac_q != last_q.code) && fifo_ready;
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            last_q <= '0;
        end else if (push) begin
            last_q.code <= dac_q;
        end
    end
    code_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .in_valid_in(push),
        .in_ready_out(fifo_ready),
        .in_data_in(dac_q),
        .out_valid_out(analog_output_valid_out),
        .out_ready_in(analog_output_ready_in),
        .out_data_out(fifo_data)
    );
    assign analog_output_out = fifo_data;
    // Linear 1 mV per step
    assign analog_output_uv_out = 32'(fifo_data) * 32'(`STEP_UV);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    // Output register
    hold_high_a: assert property (
        s_ld_n && $past(s_ld_n) && s_clr_n |=> $stable(dac_q))
        else $error("held code moved");
    load_edge_a: assert property (
        s_clr_n && !s_ld_n && ld_prev_q |=> dac_q == $past(shift_q))
        else $error("load missed");
    transp_a: assert property (
        s_clr_n && !s_ld_n |=> dac_q == $past(shift_q))
        else $error("not transparent");
    clear_a: assert property (
        !s_clr_n |=> dac_q == `CODE_ZERO)
        else $error("clear failed");
    clr_hold_a: assert property (
        !s_clr_n ##1 s_clr_n && s_ld_n |=> dac_q == `CODE_ZERO)
        else $error("zero not held");
    clr_rel_a: assert property (
        $rose(s_clr_n) && !s_ld_n |=> dac_q == $past(shift_q))
        else $error("release load");
    // Shift register
    desel_a: assert property (
        s_cs_n && $past(s_cs_n) |=> $stable(shift_q))
        else $error("shift deselected");
    clk_edge_a: assert property (
        !s_cs_n && !prev_q[1] && s_clk && !prev_q[0] |-> shift_ev)
        else $error("clock edge missed");
    cs_edge_a: assert property (
        s_cs_n && !prev_q[1] && !s_clk && !prev_q[0] |-> shift_ev)
        else $error("select edge missed");
    shift_a: assert property (
        shift_ev |=> shift_q == {$past(shift_q[10:0]), $past(s_dat)})
        else $error("bad shift");
    msb_a: assert property (
        shift_ev |=> shift_q[11] == $past(shift_q[10]))
        else $error("oldest bit kept");
    // Converter code stream
    scale_a: assert property (
        analog_output_uv_out == 32'(analog_output_out) * 32'(`STEP_UV))
        else $error("scale");
    c_load: cover property (s_clr_n && !s_ld_n && ld_prev_q);
    c_clear: cover property (!s_clr_n ##1 s_clr_n);
    c_shift: cover property (shift_ev);
    c_cs_edge: cover property (s_cs_n && !prev_q[1] && !s_clk);
    c_full: cover property (!fifo_ready);
endmodule : serial_dac_input_latch

// ---- testbench.sv ----
// Purpose: Self-checking bench for the converter input latch
// Assumes: Host model drives the pins, bench drives drain ready
// Notes: Expected codes queue up and are checked as they drain
`timescale 1ns/1ps
`include "dac_latch_params.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    num_errors++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module testbench;
    import dac_latch_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic rdy = 1'b0;
    logic sclk, sdata, cs_n, ld_n, clr_n, valid;
    logic [11:0] held, code;
    logic [31:0] uv;
    code_t sr = 12'h000;
    code_t last = 12'h000;
    code_t lvl[3] = '{`CODE_FULL, `CODE_MID, `CODE_ZERO};
    code_t expq[$];
    code_t e;
    logic [15:0] w;
    int num_errors = 0;
    int samples_checked = 0;
    int seed = 24;
    always #5 mclk = ~mclk;
    host_model u_host (.sclk_out(sclk), .sdata_out(sdata),
        .cs_n_out(cs_n), .ld_n_out(ld_n), .clr_n_out(clr_n));
    serial_dac_input_latch u_dut (.mclk_in(mclk), .rst_b_in(rst_b),
        .serial_clk_in(sclk), .serial_data_in(sdata),
        .chip_select_n_in(cs_n), .load_strobe_n_in(ld_n),
        .async_clear_n_in(clr_n), .held_code_out(held),
        .analog_output_valid_out(valid), .analog_output_ready_in(rdy),
        .analog_output_out(code), .analog_output_uv_out(uv));
    task automatic note(input code_t v);
        if (v !== last) begin
            expq.push_back(v);
            last = v;
        end
    endtask : note
    task automatic word(input logic [15:0] v, input int n,
                        input logic via_cs, input logic sel);
        for (int i = n - 1; i >= 0; i--) begin
            if (sel | via_cs) sr = {sr[10:0], v[i]};
            if ((sel | via_cs) && ld_n === 1'b0) note(sr);
            u_host.bit_out(v[i], via_cs, sel);
        end
    endtask : word
    task automatic load();
        note(sr);
        u_host.pins(1'b0, 1'b1);
        `CHK(held, sr)
        u_host.pins(1'b1, 1'b1);
    endtask : load
    task automatic test_done();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    always @(posedge mclk) begin
        #1 rdy <= 1'($random(seed));
    end
    always @(negedge mclk) begin
        if (rst_b && valid === 1'b1 && rdy === 1'b1) begin
            e = (expq.size() > 0) ? expq.pop_front() : 12'hxxx;
            `CHK(code, e)
            `CHK(uv, 32'(e) * `STEP_UV)
        end
    end
    initial begin
        #300000 num_errors++;
        test_done();
    end
    // ----------
    // Scenarios
    // ----------
    initial begin
        repeat (20) @(posedge mclk);
        #1 rst_b = 1'b1;
        w = 16'($random(seed));
        word(w, 12, 1'b0, 1'b1);
        `CHK(held, 12'h000)
        load();
        foreach (lvl[k]) begin
            word(16'(lvl[k]), 12, 1'b0, 1'b1);
            load();
        end
        w = 16'($random(seed));
        word(w, 12, 1'b1, 1'b0);
        word(~w, 12, 1'b0, 1'b0);
        `CHK(held, 12'h000)
        load();
        `CHK(held, sr)
        w = 16'($random(seed));
        word(w, 16, 1'b0, 1'b1);
        load();
        note(12'h000);
        u_host.pins(1'b1, 1'b0);
        `CHK(held, 12'h000)
        u_host.pins(1'b0, 1'b0);
        u_host.pins(1'b1, 1'b1);
        `CHK(held, 12'h000)
        u_host.pins(1'b0, 1'b0);
        note(sr);
        u_host.pins(1'b0, 1'b1);
        `CHK(held, sr)
        w = 16'($random(seed));
        word(w, 12, 1'b0, 1'b1);
        `CHK(held, sr)
        u_host.pins(1'b1, 1'b1);
        repeat (300) @(posedge mclk);
        `CHK(32'(expq.size()), 32'h0)
        test_done();
    end
endmodule : testbench
